// File: design/arfr_map.vh
// Purpose: Register map, field positions and reset values for the result format block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Contract list follows
// Contract
// [RL1] Left justify: result 9..2 into high
// [RL2] Left justify: result 1..0 into low 7..6
// [RL3] Right justify: result 9..8 into high 1..0
// [RL4] Right justify: result 7..0 into low
// [RL5] Software waits acquisition after channel change
// [RL6] Acquisition wait is amplifier, charge, temperature
// [RL7] Unused six bits forced zero on load
// [RL8] Start flag clears when result loads
// [RL9] Result registers writable, keep value over reset
`ifndef ARFR_MAP_VH
`define ARFR_MAP_VH
`define ARFR_OFF_CTRL 4'h0
`define ARFR_OFF_CFG 4'h4
`define ARFR_OFF_RESH 4'h8
`define ARFR_OFF_RESL 4'hc
`define ARFR_OFF_IRQ_STAT 5'h10
`define ARFR_OFF_IRQ_MASK 5'h14
`define ARFR_CTRL_ON 0
`define ARFR_CTRL_GO 1
`define ARFR_CTRL_CHS_LO 2
`define ARFR_CTRL_CHS_HI 6
`define ARFR_CFG_FMT 7
`define ARFR_CFG_MASK 8'hf3
`define ARFR_CTRL_MASK 8'h7f
`define ARFR_RST_BYTE 8'h00
`define ARFR_RESP_OKAY 2'b00
`define ARFR_RESP_SLVERR 2'b10
`define ARFR_ZERO6 6'h00
`define ARFR_IDX_CTRL 3'h0
`define ARFR_IDX_CFG 3'h1
`define ARFR_IDX_RESH 3'h2
`define ARFR_IDX_RESL 3'h3
`define ARFR_IDX_IRQ_STAT 3'h4
`define ARFR_IDX_IRQ_MASK 3'h5
`define ARFR_CFG_CLK_HI 6
`define ARFR_CFG_CLK_LO 4
`define ARFR_CFG_REF_HI 1
`define ARFR_CFG_REF_LO 0
`endif

// File: design/arfr_fmt.v
// Purpose: Justify a 10-bit result into a high/low byte pair
// Assumes: Pure combinational
// Notes: Unused bits always zero, never stale
`include "arfr_map.vh"
module arfr_fmt (
  // Input result
  input wire [9:0] result,
  input wire justify_select,
  // Formatted bytes
  output reg [7:0] high_byte,
  output reg [7:0] low_byte
);
  // Pick layout by justify bit
  always @* begin
    if (justify_select) begin
      high_byte = {`ARFR_ZERO6, result[9:8]}; // see [RL3] see [RL7]
      low_byte = result[7:0]; // see [RL4]
    end else begin
      high_byte = result[9:2]; // see [RL1]
      low_byte = {result[1:0], `ARFR_ZERO6}; // see [RL2] see [RL7]
    end
  end
endmodule // arfr_fmt

// File: design/arfr_top.v
// Purpose: Register side of a 10-bit converter with AXI4-Lite slave
// Assumes: Converter core on aclk; done pulse carries the result
// Notes: Software owns the acquisition wait before setting start
`include "arfr_map.vh"
module arfr_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write address channel
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // Write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // Write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // Read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Converter core
  input wire [9:0] conversion_result,
  input wire conv_done,
  output reg conv_start_q,
  output reg converter_enable_q,
  output reg [4:0] channel_select_q,
  output reg [2:0] conversion_clock_select_q,
  output reg [1:0] positive_reference_select_q,
  // Interrupt
  output reg irq_q
);
  reg [7:0] ctrl_q; // Channel control register
  reg [7:0] cfg_q; // Clock and format config register
  reg [7:0] result_high_reg_q; // High result byte
  reg [7:0] result_low_reg_q; // Low result byte
  reg [1:0] irq_stat_q; // Bit0 done, bit1 aborted
  reg [1:0] irq_mask_q; // Same layout as status
  reg aw_got_q; // Write address held
  reg w_got_q; // Write data held
  reg [4:0] awaddr_q; // Captured write byte address, low bits only
  reg [7:0] wbyte_q; // Captured low data byte; upper lanes unused
  reg wstrb0_q; // Low byte lane enable of the captured write
  wire [7:0] fmt_high; // Justified high byte, ready to load
  wire [7:0] fmt_low; // Justified low byte, ready to load
  // Word index of the held write; upper address bits alias onto the map
  wire [2:0] wr_idx = awaddr_q[4:2];
  // Conversion in progress as software sees it
  wire go_now = ctrl_q[`ARFR_CTRL_GO];
  // A held address and data pair, not yet answered
  wire do_write = aw_got_q && w_got_q && !s_axi_bvalid;
  // Registers change only in the answering cycle, low lane only
  wire wr_en = do_write && wstrb0_q;
  // Control register written this cycle
  wire wr_ctrl = wr_en && (wr_idx == `ARFR_IDX_CTRL);
  // Software clearing the go bit terminates early; partial result still loads
  wire go_clear_sw = wr_ctrl && go_now && !wbyte_q[`ARFR_CTRL_GO];
  // Finished or cut conversion both latch the core's present result
  wire load = go_now && (conv_done || go_clear_sw);
  // Finished conversion seen while go is set; a stray done is ignored
  wire done_ok = conv_done && go_now;

  arfr_fmt u_fmt (
    .result(conversion_result),
    .justify_select(cfg_q[`ARFR_CFG_FMT]),
    .high_byte(fmt_high),
    .low_byte(fmt_low)
  );

  // Write channel handshake: address and data taken independently
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARFR_RESP_OKAY;
      awaddr_q <= 5'h00;
      wbyte_q <= `ARFR_RST_BYTE;
      wstrb0_q <= 1'b0;
    end else begin
      // Ready pulses once; a second request waits for the answer
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      // Capture address on handshake
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr[4:0];
      end
      // Capture data on handshake
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      // Respond once both are held
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        // Word indices past the mask register are refused
        if (wr_idx > `ARFR_IDX_IRQ_MASK)
          s_axi_bresp <= `ARFR_RESP_SLVERR;
        else
          s_axi_bresp <= `ARFR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Control and config; go clears itself on completion
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `ARFR_RST_BYTE;
      cfg_q <= `ARFR_RST_BYTE;
      irq_mask_q <= 2'b00;
    end else begin
      // Reserved bits read back as zero through the masks
      if (wr_ctrl)
        ctrl_q <= wbyte_q & `ARFR_CTRL_MASK;
      if (wr_en && wr_idx == `ARFR_IDX_CFG)
        cfg_q <= wbyte_q & `ARFR_CFG_MASK;
      if (wr_en && wr_idx == `ARFR_IDX_IRQ_MASK)
        irq_mask_q <= wbyte_q[1:0];
      // Hardware clear beats a same-cycle software rewrite of go
      if (done_ok)
        ctrl_q[`ARFR_CTRL_GO] <= 1'b0; // see [RL8]
      // Go cannot start while the converter is off
      if (wr_ctrl && !wbyte_q[`ARFR_CTRL_ON])
        ctrl_q[`ARFR_CTRL_GO] <= 1'b0;
    end
  end

  // Result bytes: no reset, so contents survive a bus reset
  always @(posedge aclk) begin
    // A load and a bus write in one cycle: the load wins
    if (load) begin
      result_high_reg_q <= fmt_high; // see [RL1] see [RL3] see [RL8]
      result_low_reg_q <= fmt_low; // see [RL2] see [RL4]
    end else begin
      if (wr_en && wr_idx == `ARFR_IDX_RESH)
        result_high_reg_q <= wbyte_q; // see [RL9]
      if (wr_en && wr_idx == `ARFR_IDX_RESL)
        result_low_reg_q <= wbyte_q; // see [RL9]
    end
  end

  // Sticky events; set wins over write-one-to-clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      // An event in the clearing cycle survives the clear
      if (wr_en && wr_idx == `ARFR_IDX_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~wbyte_q[1:0]) | {go_clear_sw, done_ok};
      else
        irq_stat_q <= irq_stat_q | {go_clear_sw, done_ok};
      // Pin follows status and mask one cycle late
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Core-facing outputs from flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_start_q <= 1'b0;
      converter_enable_q <= 1'b0;
      channel_select_q <= 5'h00;
      conversion_clock_select_q <= 3'h0;
      positive_reference_select_q <= 2'h0;
    end else begin
      // Start level; software alone ensures the acquisition wait,
      // so an early go converts an input that has not settled
      conv_start_q <= go_now && ctrl_q[`ARFR_CTRL_ON] && !conv_done;
      converter_enable_q <= ctrl_q[`ARFR_CTRL_ON];
      channel_select_q <= ctrl_q[`ARFR_CTRL_CHS_HI:`ARFR_CTRL_CHS_LO];
      conversion_clock_select_q <= cfg_q[`ARFR_CFG_CLK_HI:`ARFR_CFG_CLK_LO];
      positive_reference_select_q <= cfg_q[`ARFR_CFG_REF_HI:`ARFR_CFG_REF_LO];
    end
  end

  // Read channel: one-cycle accept, data next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ARFR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ARFR_RESP_OKAY;
        // Upper address bits are not decoded, so the map repeats
        case (s_axi_araddr[4:2])
          `ARFR_IDX_CTRL: s_axi_rdata <= {24'h0, ctrl_q};
          `ARFR_IDX_CFG: s_axi_rdata <= {24'h0, cfg_q};
          `ARFR_IDX_RESH: s_axi_rdata <= {24'h0, result_high_reg_q};
          `ARFR_IDX_RESL: s_axi_rdata <= {24'h0, result_low_reg_q};
          `ARFR_IDX_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_q};
          `ARFR_IDX_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_q};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ARFR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // arfr_top

// File: tb/arfr_chk.sv
// Purpose: Bus and conversion timing checks on the result format block
// Assumes: One clock, sync active-low reset
// Notes: Byte layout of results is judged by the bench
module arfr_chk (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bus answers
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [1:0] s_axi_rresp,
  input logic [31:0] s_axi_rdata,
  // Converter side
  input logic conv_done,
  input logic conv_start_q,
  input logic converter_enable_q
);
  // One domain, so reset masks every check here
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_go_clear; conv_done && conv_start_q |-> ##[1:2] !conv_start_q; endproperty
  a_go_clear: assert property (p_go_clear) else $error("start flag stuck");
  property p_start_on; conv_start_q |-> converter_enable_q; endproperty
  a_start_on: assert property (p_start_on) else $error("start while off");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read data");
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_b_rel; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_rel: assert property (p_b_rel) else $error("write answer repeated");
  property p_r_rel; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_rel: assert property (p_r_rel) else $error("read answer repeated");
  property p_r_err; s_axi_rvalid && s_axi_rresp != 2'b00 |-> s_axi_rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("refused read not zero");
endmodule // arfr_chk

bind arfr_top arfr_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata),
  .conv_done(conv_done),
  .conv_start_q(conv_start_q),
  .converter_enable_q(converter_enable_q)
);

// File: tb/adc_result_format_regs_tb_top.sv
// Purpose: Self-checking bench for the result format block
// Assumes: Bench is bus master and converter core
// Notes: Expected reads are queued, a monitor matches them
`include "arfr_map.vh"
module adc_result_format_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset, counters, expectations
  logic aclk = 0, aresetn = 0, done = 0;
  int fails = 0, checks = 0;
  logic [15:0] lfsr = 16'hc1cf;
  logic [33:0] expq[$], e;
  logic [1:0] bq[$], eb; // Expected write answers, oldest first
  logic start, enable; // Start level and enable from the block
  logic [4:0] chan; // Channel select output
  logic [2:0] clksel; // Conversion clock select output
  logic [1:0] refsel; // Reference select output
  localparam int ACQ = 4; // Acquisition wait in cycles, software's own choice
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [9:0] res = 0;
  wire [33:0] got = {rresp, rdata};
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
  always #5 aclk = ~aclk;
  arfr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conversion_result(res), .conv_done(done), .conv_start_q(start),
    .converter_enable_q(enable), .channel_select_q(chan),
    .conversion_clock_select_q(clksel), .positive_reference_select_q(refsel),
    .irq_q(irq));
  // Monitor: every read answer takes the oldest note
  always @(posedge aclk) if (rvalid && rready) begin
    e = expq.pop_front();
    `CHK(got, e)
  end
  // Monitor: every write answer takes the oldest note
  always @(posedge aclk) if (bvalid && bready) begin
    eb = bq.pop_front();
    `CHK(bresp, eb)
  end
  // Next random value of the bench's shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic print_verdict;
    $display("Counts: checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bus write; a bounded wait, a hang counts as a mismatch
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    bq.push_back((a > `ARFR_OFF_IRQ_MASK) ? `ARFR_RESP_SLVERR : `ARFR_RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && n < 50);
    bready <= 0;
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
    @(posedge aclk);
  endtask
  // Bus read; the note is queued before the request
  task automatic rd(input logic [31:0] a, input logic [33:0] x);
    int n;
    n = 0;
    expq.push_back(x);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 0;
    end while (!rvalid && n < 50);
    rready <= 0;
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
    @(posedge aclk);
  endtask
  // One conversion with random result, channel and config fields
  task automatic conv(input logic f);
    logic [7:0] c;
    logic [7:0] k;
    lfsr = lfsr_next(lfsr);
    res <= lfsr[9:0];
    c = {f, lfsr[12:10], 2'b00, lfsr[15:14]};
    k = {1'b0, lfsr[14:10], 2'b01};
    wr(`ARFR_OFF_CFG, {24'h0, c});
    wr(`ARFR_OFF_CTRL, {24'h0, k});
    rd(`ARFR_OFF_CFG, {26'h0, c});
    `CHK({clksel, refsel, enable, chan}, {c[6:4], c[1:0], 1'b1, k[6:2]})
    repeat (ACQ) @(posedge aclk); // Settle after channel pick
    wr(`ARFR_OFF_CTRL, {24'h0, k | 8'h02});
    `CHK(start, 1'b1)
    done <= 1;
    @(posedge aclk);
    done <= 0;
    rd(`ARFR_OFF_RESH, {26'h0, f ? {6'h0, res[9:8]} : res[9:2]});
    rd(`ARFR_OFF_RESL, {26'h0, f ? res[7:0] : {res[1:0], 6'h0}});
    rd(`ARFR_OFF_CTRL, {26'h0, k});
    `CHK(start, 1'b0)
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`ARFR_OFF_CTRL, 34'h0);
    rd(`ARFR_OFF_CFG, 34'h0);
    $display("Test reset values done");
    wr(`ARFR_OFF_IRQ_MASK, 32'h1);
    for (int i = 0; i < 6; i++) conv(i[0]);
    `CHK(irq, 1'b1)
    wr(`ARFR_OFF_IRQ_STAT, 32'h3);
    @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(`ARFR_OFF_IRQ_STAT, 34'h0);
    $display("Test conversions done");
    // Early stop: clearing go loads the partial result and flags it
    res <= ~res;
    wr(`ARFR_OFF_CTRL, 32'h17);
    wr(`ARFR_OFF_CTRL, 32'h15);
    rd(`ARFR_OFF_RESH, {26'h0, 6'h0, res[9:8]});
    rd(`ARFR_OFF_RESL, {26'h0, res[7:0]});
    rd(`ARFR_OFF_IRQ_STAT, 34'h2);
    $display("Test early stop done");
    wr(`ARFR_OFF_RESH, 32'ha5);
    wr(`ARFR_OFF_RESL, 32'h3c);
    aresetn <= 0;
    @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`ARFR_OFF_RESH, 34'ha5);
    rd(`ARFR_OFF_RESL, 34'h3c);
    wr(32'h18, 32'hff);
    rd(32'h18, {2'b10, 32'h0});
    rd(`ARFR_OFF_CTRL, 34'h0);
    $display("Test result keep done");
    print_verdict();
  end
endmodule // adc_result_format_regs_tb_top
